// ### verilog/uspd_top.sv
// USB status flags and multiplexed pin function control.
//
// Notes on behaviour
// - Flag A asserts for only the first cycle of a bus reset, if chosen; the reset reloads a setup that drops it.
// - Flag A asserts while the device is suspended, if chosen.
// - Unsafe current with power at or below one unit load: assert during suspend.
// - Unsafe current with power above one unit load: assert until configured.
// - Flag A polarity and conditions come from its own setup register.
// - A flag deasserts whenever none of its chosen conditions holds.
// - Flag A resets to active high, asserted only during suspend.
// - Flag B acts like A but resets to active low during suspend.
// - Receive indicator, default push-pull, toggles near 10 Hz while receiving.
// - Transmit indicator, default push-pull, toggles near 10 Hz while transmitting.
// - Set-ready pin is an active-low input when selected, else GPIO output.
// - Terminal-ready pin is an active-low push-pull output when selected, else GPIO output.
// - Ring pin is active-low ring or wakeup input, default GPIO input with pull-up.
// - Carrier pin is an active-low input when selected, default GPIO input with pull-up.
// - Half-duplex pin defaults to active-high push-pull transceiver enable, else GPIO.
// - Clear-to-send pin defaults to active-low input with pull-up, else GPIO.
// - Request-to-send defaults to open-drain active-low output, or half-duplex enable, or GPIO.
// - Enabled pull resistors stay enabled during suspend.
// - Bus reset returns runtime pin settings to their defaults and disables resistors until it ends.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uspd_top #(
  parameter longint unsigned ACT_TOGGLE_CYCLES = uspd_pkg::ACT_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic [uspd_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [uspd_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output var  logic [uspd_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                        usb_bus_reset,
  input  wire logic                        usb_suspended,
  input  wire logic                        usb_configured,
  input  wire logic                        uart_rx_busy,
  input  wire logic                        uart_tx_busy,
  input  wire logic                        half_duplex_drive,
  input  wire logic                        send_request,
  input  wire logic                        terminal_ready,
  output var  logic                        bus_state_flag_a_out,
  output var  logic                        bus_state_flag_a_oe,
  output var  logic                        bus_state_flag_b_out,
  output var  logic                        bus_state_flag_b_oe,
  input  wire logic [uspd_pkg::NPIN-1:0]   pin_in,
  output var  logic [uspd_pkg::NPIN-1:0]   pin_out,
  output var  logic [uspd_pkg::NPIN-1:0]   pin_oe,
  output var  logic [uspd_pkg::NPIN-1:0]   pin_pull_en,
  output var  logic                        set_ready_active,
  output var  logic                        carrier_active,
  output var  logic                        ring_active,
  output var  logic                        wakeup_request,
  output var  logic                        clear_to_send_active
);
  import uspd_pkg::*;

  localparam int unsigned CNT_W = $clog2(ACT_TOGGLE_CYCLES + 1);

  generate
    if (ACT_TOGGLE_CYCLES < 2) begin : g_bad_cycles
      $error("ACT_TOGGLE_CYCLES must be at least 2.");
    end
  endgenerate

  // Software visible state.
  logic [FLG_W-1:0] flag_a_pin_setup;
  logic [FLG_W-1:0] flag_b_pin_setup;
  logic [FN_W-1:0]  pin_func;
  logic [NPIN-1:0]  gpio_dir;
  logic [NPIN-1:0]  gpio_out;
  logic [NPIN-1:0]  pull_en;
  logic [7:0]       max_power;

  // Address decode.
  wire hit_flag_a = (reg_addr == OFS_FLAG_A);
  wire hit_flag_b = (reg_addr == OFS_FLAG_B);
  wire hit_func   = (reg_addr == OFS_PIN_FUNC);
  wire hit_dir    = (reg_addr == OFS_GPIO_DIR);
  wire hit_out    = (reg_addr == OFS_GPIO_OUT);
  wire hit_pull   = (reg_addr == OFS_PULL_EN);
  wire hit_status = (reg_addr == OFS_STATUS);
  wire hit_power  = (reg_addr == OFS_MAX_PWR);

  // Runtime settings fall back to their defaults for the whole of a bus reset; writes are ignored meanwhile.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_a_pin_setup <= FLAG_A_RST;
      flag_b_pin_setup <= FLAG_B_RST;
      pin_func         <= PIN_FUNC_RST;
      gpio_dir         <= GPIO_DIR_RST;
      gpio_out         <= GPIO_OUT_RST;
      pull_en          <= PULL_EN_RST;
      max_power        <= MAX_PWR_RST;
    end else if (usb_bus_reset) begin
      flag_a_pin_setup <= FLAG_A_RST;
      flag_b_pin_setup <= FLAG_B_RST;
      pin_func         <= PIN_FUNC_RST;
      gpio_dir         <= GPIO_DIR_RST;
      gpio_out         <= GPIO_OUT_RST;
      pull_en          <= PULL_EN_RST;
      max_power        <= MAX_PWR_RST;
    end else if (reg_wr) begin
      if (hit_flag_a) begin
        flag_a_pin_setup <= reg_wdata[FLG_W-1:0];
      end else if (hit_flag_b) begin
        flag_b_pin_setup <= reg_wdata[FLG_W-1:0];
      end else if (hit_func) begin
        pin_func <= reg_wdata[FN_W-1:0];
      end else if (hit_dir) begin
        gpio_dir <= reg_wdata[NPIN-1:0];
      end else if (hit_out) begin
        gpio_out <= reg_wdata[NPIN-1:0];
      end else if (hit_pull) begin
        pull_en <= reg_wdata[NPIN-1:0];
      end else if (hit_power) begin
        max_power <= reg_wdata[7:0];
      end
    end
  end

  // Pin input synchroniser: a level counts once the second and third stages agree.
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] pin_level;

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sync1[g]     <= 1'b1;
          sync2[g]     <= 1'b1;
          sync3[g]     <= 1'b1;
          pin_level[g] <= 1'b1;
        end else begin
          sync1[g] <= pin_in[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            pin_level[g] <= sync3[g];
          end
        end
      end
    end
  endgenerate

  // USB status conditions.
  wire low_power_cfg = (max_power <= ONE_UNIT_LOAD);
  wire unsafe_now    = low_power_cfg ? usb_suspended : !usb_configured;
  wire [FLG_W-1:0] cond_vec = {unsafe_now, usb_suspended, usb_bus_reset, 1'b0};

  wire flag_a_hit = |(flag_a_pin_setup[FLG_W-1:1] & cond_vec[FLG_W-1:1]);
  wire flag_b_hit = |(flag_b_pin_setup[FLG_W-1:1] & cond_vec[FLG_W-1:1]);
  wire flag_a_lvl = flag_a_pin_setup[FLG_POL] ? flag_a_hit : !flag_a_hit;
  wire flag_b_lvl = flag_b_pin_setup[FLG_POL] ? flag_b_hit : !flag_b_hit;

  // Activity indicators run from a one-cycle enable divided down from the core clock.
  logic [CNT_W-1:0] act_cnt;
  logic             act_tick;
  wire              act_wrap = (act_cnt == CNT_W'(ACT_TOGGLE_CYCLES - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      act_cnt  <= '0;
      act_tick <= 1'b0;
    end else begin
      act_cnt  <= act_wrap ? '0 : act_cnt + 1'b1;
      act_tick <= act_wrap;
    end
  end

  uspd_act_if act ();
  assign act.tick = act_tick;
  assign act.busy = {uart_tx_busy, uart_rx_busy};

  uspd_blink u_blink (
    .clk    (clk),
    .resetn (resetn),
    .clear  (usb_bus_reset),
    .act    (act)
  );

  // Alternate function drive of each pin.
  wire [NPIN-1:0] alt_out;
  wire [NPIN-1:0] alt_oe;
  wire            req_hdx = pin_func[FN_REQ_HDX];

  assign alt_out[PIN_RX_ACT]  = act.led[0];
  assign alt_oe[PIN_RX_ACT]   = 1'b1;
  assign alt_out[PIN_TX_ACT]  = act.led[1];
  assign alt_oe[PIN_TX_ACT]   = 1'b1;
  assign alt_out[PIN_SET_RDY] = 1'b0;
  assign alt_oe[PIN_SET_RDY]  = 1'b0;
  assign alt_out[PIN_TRM_RDY] = !terminal_ready;
  assign alt_oe[PIN_TRM_RDY]  = 1'b1;
  assign alt_out[PIN_RING]    = 1'b0;
  assign alt_oe[PIN_RING]     = 1'b0;
  assign alt_out[PIN_CARRIER] = 1'b0;
  assign alt_oe[PIN_CARRIER]  = 1'b0;
  assign alt_out[PIN_HALF_DX] = half_duplex_drive;
  assign alt_oe[PIN_HALF_DX]  = 1'b1;
  assign alt_out[PIN_CLR_SND] = 1'b0;
  assign alt_oe[PIN_CLR_SND]  = 1'b0;
  // Open drain request line only ever pulls low, the board pull-up gives the idle high.
  assign alt_out[PIN_REQ_SND] = req_hdx ? half_duplex_drive : 1'b0;
  assign alt_oe[PIN_REQ_SND]  = req_hdx ? 1'b1 : send_request;

  wire [NPIN-1:0] alt_sel  = pin_func[NPIN-1:0];
  wire [NPIN-1:0] next_out = (alt_sel & alt_out) | (~alt_sel & gpio_out);
  wire [NPIN-1:0] next_oe  = (alt_sel & alt_oe) | (~alt_sel & gpio_dir);
  // Suspend has no say over the resistors; only a bus reset takes them off.
  wire [NPIN-1:0] next_pull = usb_bus_reset ? '0 : pull_en;

  // Modem inputs are active low and only reported while their function is selected.
  wire next_set_ready = alt_sel[PIN_SET_RDY] && !pin_level[PIN_SET_RDY];
  wire next_carrier   = alt_sel[PIN_CARRIER] && !pin_level[PIN_CARRIER];
  wire ring_low       = alt_sel[PIN_RING] && !pin_level[PIN_RING];
  wire next_ring      = ring_low && !pin_func[FN_RING_WAKE];
  wire next_wakeup    = ring_low && pin_func[FN_RING_WAKE];
  wire next_clear     = alt_sel[PIN_CLR_SND] && !pin_level[PIN_CLR_SND];

  // Read mux.
  wire [DATA_W-1:0] status_word = {
    {(DATA_W-ST_UNSAFE-1){1'b0}}, unsafe_now, flag_b_lvl, flag_a_lvl,
    usb_configured, usb_suspended, usb_bus_reset,
    {(ST_BUS_RESET-NPIN){1'b0}}, pin_level
  };
  wire [DATA_W-1:0] next_rdata =
    !reg_rd    ? '0 :
    hit_flag_a ? DATA_W'(flag_a_pin_setup) :
    hit_flag_b ? DATA_W'(flag_b_pin_setup) :
    hit_func   ? DATA_W'(pin_func) :
    hit_dir    ? DATA_W'(gpio_dir) :
    hit_out    ? DATA_W'(gpio_out) :
    hit_pull   ? DATA_W'(pull_en) :
    hit_status ? status_word :
    hit_power  ? DATA_W'(max_power) : '0;

  // Output registers.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata            <= '0;
      bus_state_flag_a_out <= 1'b0;
      bus_state_flag_a_oe  <= 1'b1;
      bus_state_flag_b_out <= 1'b0;
      bus_state_flag_b_oe  <= 1'b0;
      pin_out              <= '0;
      pin_oe               <= '0;
      pin_pull_en          <= '0;
      set_ready_active     <= 1'b0;
      carrier_active       <= 1'b0;
      ring_active          <= 1'b0;
      wakeup_request       <= 1'b0;
      clear_to_send_active <= 1'b0;
    end else begin
      reg_rdata            <= next_rdata;
      bus_state_flag_a_out <= 1'b0;
      bus_state_flag_a_oe  <= !flag_a_lvl;
      bus_state_flag_b_out <= 1'b0;
      bus_state_flag_b_oe  <= !flag_b_lvl;
      pin_out              <= next_out;
      pin_oe               <= next_oe;
      pin_pull_en          <= next_pull;
      set_ready_active     <= next_set_ready;
      carrier_active       <= next_carrier;
      ring_active          <= next_ring;
      wakeup_request       <= next_wakeup;
      clear_to_send_active <= next_clear;
    end
  end
endmodule : uspd_top
`default_nettype wire

// ### verilog/uspd_pkg.sv
// Constants shared by the USB status and pin function block.
package uspd_pkg;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned NPIN        = 9;
  localparam int unsigned NACT        = 2;

  // Register offsets.
  localparam logic [7:0] OFS_FLAG_A   = 8'h00;
  localparam logic [7:0] OFS_FLAG_B   = 8'h04;
  localparam logic [7:0] OFS_PIN_FUNC = 8'h08;
  localparam logic [7:0] OFS_GPIO_DIR = 8'h0c;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h10;
  localparam logic [7:0] OFS_PULL_EN  = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_MAX_PWR  = 8'h1c;

  // Status flag setup fields.
  localparam int unsigned FLG_POL     = 0;
  localparam int unsigned FLG_RESET   = 1;
  localparam int unsigned FLG_SUSP    = 2;
  localparam int unsigned FLG_POWER   = 3;
  localparam int unsigned FLG_W       = 4;
  localparam logic [3:0] FLAG_A_RST   = 4'h5;
  localparam logic [3:0] FLAG_B_RST   = 4'h4;

  // Pin indices, shared by the function, direction, output, pull and status fields.
  localparam int unsigned PIN_RX_ACT  = 0;
  localparam int unsigned PIN_TX_ACT  = 1;
  localparam int unsigned PIN_SET_RDY = 2;
  localparam int unsigned PIN_TRM_RDY = 3;
  localparam int unsigned PIN_RING    = 4;
  localparam int unsigned PIN_CARRIER = 5;
  localparam int unsigned PIN_HALF_DX = 6;
  localparam int unsigned PIN_CLR_SND = 7;
  localparam int unsigned PIN_REQ_SND = 8;

  // Function register: bits 8:0 pick the alternate function, 9 and 10 pick its flavour.
  localparam int unsigned FN_RING_WAKE = 9;
  localparam int unsigned FN_REQ_HDX   = 10;
  localparam int unsigned FN_W         = 11;
  localparam logic [10:0] PIN_FUNC_RST = 11'h1c3;
  localparam logic [8:0]  GPIO_DIR_RST = 9'h00c;
  localparam logic [8:0]  GPIO_OUT_RST = 9'h000;
  localparam logic [8:0]  PULL_EN_RST  = 9'h0b0;

  // Power figure of one unit load and the default descriptor value.
  localparam logic [7:0] ONE_UNIT_LOAD = 8'h32;
  localparam logic [7:0] MAX_PWR_RST   = 8'h32;

  // Status register fields above the pin levels.
  localparam int unsigned ST_BUS_RESET = 16;
  localparam int unsigned ST_SUSPEND   = 17;
  localparam int unsigned ST_CONFIG    = 18;
  localparam int unsigned ST_FLAG_A    = 19;
  localparam int unsigned ST_FLAG_B    = 20;
  localparam int unsigned ST_UNSAFE    = 21;

  // Activity indicator timing.
  localparam longint unsigned CLK_HZ        = 200_000_000;
  localparam longint unsigned ACT_TOGGLE_MS = 100;
  localparam longint unsigned ACT_CYCLES    = (CLK_HZ / 1000) * ACT_TOGGLE_MS;
endpackage : uspd_pkg

// ### verilog/uspd_act_if.sv
// Interface that carries the activity indicator signals between the top and the blinker.
`timescale 1ns/1ps
`default_nettype none
interface uspd_act_if;
  logic       tick;
  logic [1:0] busy;
  logic [1:0] led;
  modport ctrl (output tick, output busy, input led);
  modport blink (input tick, input busy, output led);
endinterface : uspd_act_if
`default_nettype wire

// ### verilog/uspd_blink.sv
// Activity indicator toggles for the receive and transmit channels.
`timescale 1ns/1ps
`default_nettype none
module uspd_blink (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic clear,
  uspd_act_if.blink act
);
  import uspd_pkg::*;

  genvar g;
  generate
    for (g = 0; g < NACT; g++) begin : g_ch
      logic state;
      // The indicator rests low when idle so an unlit LED means no traffic.
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          state <= 1'b0;
        end else if (clear || !act.busy[g]) begin
          state <= 1'b0;
        end else if (act.tick) begin
          state <= ~state;
        end
      end
      assign act.led[g] = state;
    end
  endgenerate
endmodule : uspd_blink
`default_nettype wire

// ### verif/uspd_top_props.sv
// Concurrent checks on the ports of the USB status and pin function block.
`timescale 1ns/1ps
`default_nettype none
module uspd_top_props (
  input wire logic                        clk,
  input wire logic                        resetn,
  input wire logic [uspd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [uspd_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                        usb_bus_reset,
  input wire logic                        usb_suspended,
  input wire logic                        half_duplex_drive,
  input wire logic                        send_request,
  input wire logic                        bus_state_flag_a_out,
  input wire logic                        bus_state_flag_a_oe,
  input wire logic                        bus_state_flag_b_out,
  input wire logic                        bus_state_flag_b_oe,
  input wire logic [uspd_pkg::NPIN-1:0]   pin_out,
  input wire logic [uspd_pkg::NPIN-1:0]   pin_oe,
  input wire logic [uspd_pkg::NPIN-1:0]   pin_pull_en,
  input wire logic                        set_ready_active,
  input wire logic                        carrier_active,
  input wire logic                        ring_active,
  input wire logic                        wakeup_request
);
  import uspd_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Two edges of bus reset leave every setup register at its default, so the outputs show the defaults.
  sequence held_reset;
    usb_bus_reset ##1 usb_bus_reset;
  endsequence
  sequence reset_ends;
    usb_bus_reset ##1 !usb_bus_reset;
  endsequence
  flag_a_default_a: assert property (
    held_reset |=> !bus_state_flag_a_out && bus_state_flag_a_oe == !$past(usb_suspended))
    else $error("flag A does not follow suspend with defaults");
  flag_b_default_a: assert property (
    held_reset |=> !bus_state_flag_b_out && bus_state_flag_b_oe == $past(usb_suspended))
    else $error("flag B does not follow suspend with defaults");
  pull_off_a: assert property (held_reset |=> pin_pull_en == '0)
    else $error("pull enabled during bus reset");
  pull_back_a: assert property (reset_ends |=> pin_pull_en == PULL_EN_RST)
    else $error("pull not restored after bus reset");
  pull_keep_a: assert property (
    $past(resetn) && !$past(usb_bus_reset) && !$past(reg_wr) && $rose(usb_suspended) && !usb_bus_reset
    |=> $stable(pin_pull_en)) else $error("pull changed on suspend");
  half_duplex_default_a: assert property (
    held_reset |=> pin_oe[PIN_HALF_DX] && pin_out[PIN_HALF_DX] == $past(half_duplex_drive))
    else $error("half duplex enable wrong");
  send_default_a: assert property (
    held_reset |=> !pin_out[PIN_REQ_SND] && pin_oe[PIN_REQ_SND] == $past(send_request))
    else $error("request to send not open drain");
  gpio_out_default_a: assert property (
    held_reset |=> pin_oe[PIN_SET_RDY] && pin_oe[PIN_TRM_RDY] && !pin_out[PIN_TRM_RDY])
    else $error("default output pins wrong");
  activity_cleared_a: assert property (
    held_reset ##1 usb_bus_reset |=> pin_out[1:0] == 2'b00 && pin_oe[1:0] == 2'b11)
    else $error("indicators not cleared");
  modem_idle_a: assert property (
    held_reset |=> !ring_active && !wakeup_request && !carrier_active && !set_ready_active)
    else $error("modem input active on default pins");
  default_read_a: assert property (
    reg_rd && reg_addr == OFS_PIN_FUNC && usb_bus_reset && $past(usb_bus_reset)
    |=> reg_rdata == {21'h0, PIN_FUNC_RST}) else $error("function default not read back");
endmodule : uspd_top_props
bind uspd_top uspd_top_props u_props (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_bus_reset(usb_bus_reset), .usb_suspended(usb_suspended),
  .half_duplex_drive(half_duplex_drive), .send_request(send_request),
  .bus_state_flag_a_out(bus_state_flag_a_out), .bus_state_flag_a_oe(bus_state_flag_a_oe),
  .bus_state_flag_b_out(bus_state_flag_b_out), .bus_state_flag_b_oe(bus_state_flag_b_oe),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en), .set_ready_active(set_ready_active),
  .carrier_active(carrier_active), .ring_active(ring_active), .wakeup_request(wakeup_request));
`default_nettype wire

// ### verif/uspd_board.sv
// Board model: pull-ups on the open-drain flags and the level seen on each multiplexed pin.
`timescale 1ns/1ps
`default_nettype none
module uspd_board (
  input  wire logic                      clk,
  input  wire logic                      flag_a_oe,
  input  wire logic                      flag_b_oe,
  input  wire logic [uspd_pkg::NPIN-1:0] pin_out,
  input  wire logic [uspd_pkg::NPIN-1:0] pin_oe,
  input  wire logic [uspd_pkg::NPIN-1:0] pin_pull_en,
  input  wire logic [uspd_pkg::NPIN-1:0] ext_drv,
  input  wire logic [uspd_pkg::NPIN-1:0] ext_en,
  output logic                           flag_a_level,
  output logic                           flag_b_level,
  output logic [uspd_pkg::NPIN-1:0]      pin_level
);
  import uspd_pkg::*;
  logic [NPIN-1:0] float_q = '0;
  // A floating pin has no defined level, so it flips every cycle to expose any reliance on it.
  always_ff @(posedge clk) float_q <= ~float_q;
  assign flag_a_level = !flag_a_oe;
  assign flag_b_level = !flag_b_oe;
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv) | (~pin_oe & ~ext_en & (pin_pull_en | float_q));
endmodule : uspd_board
`default_nettype wire

// ### verif/uspd_top_tb.sv
// Self-checking bench for the USB status and pin function block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module uspd_top_tb;
  import uspd_pkg::*;
  typedef struct packed {logic [3:0] setup; logic [7:0] pwr; logic s; logic c; logic lvl;} uspd_row_t;
  logic              clk, resetn, reg_wr, reg_rd, bus_rst, susp, cfg, rx_busy, tx_busy, hdx, send_req, term_req;
  logic              fa_out, fa_oe, fb_out, fb_oe, fa_lvl, fb_lvl, set_act, car_act, ring_act, wake_req, clr_act;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd;
  logic [NPIN-1:0]   pin_in, pin_out, pin_oe, pull_en, ext_drv, ext_en;
  logic [1:0]        pv;
  int                mismatches, comparisons, n_rx, n_tx;
  logic [7:0]        offs [8] = '{OFS_FLAG_A, OFS_FLAG_B, OFS_PIN_FUNC, OFS_GPIO_DIR, OFS_GPIO_OUT, OFS_PULL_EN,
                                  OFS_MAX_PWR, 8'h20};
  logic [DATA_W-1:0] defs [8] = '{32'h5, 32'h4, 32'h1c3, 32'h00c, 32'h0, 32'h0b0, 32'h32, 32'h0};
  uspd_row_t         rows [10] = '{{4'h5, 8'h32, 3'b101}, {4'h5, 8'h32, 3'b010}, {4'h4, 8'h32, 3'b100},
                                   {4'h4, 8'h32, 3'b001}, {4'h9, 8'h32, 3'b111}, {4'h9, 8'h32, 3'b000},
                                   {4'h9, 8'h33, 3'b001}, {4'h9, 8'h33, 3'b110}, {4'h0, 8'h32, 3'b101},
                                   {4'h2, 8'h33, 3'b101}};
  uspd_top #(.ACT_TOGGLE_CYCLES(8)) DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_bus_reset(bus_rst), .usb_suspended(susp),
    .usb_configured(cfg), .uart_rx_busy(rx_busy), .uart_tx_busy(tx_busy), .half_duplex_drive(hdx),
    .send_request(send_req), .terminal_ready(term_req), .bus_state_flag_a_out(fa_out), .bus_state_flag_a_oe(fa_oe),
    .bus_state_flag_b_out(fb_out), .bus_state_flag_b_oe(fb_oe), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_en(pull_en), .set_ready_active(set_act), .carrier_active(car_act),
    .ring_active(ring_act), .wakeup_request(wake_req), .clear_to_send_active(clr_act));
  uspd_board board (.clk(clk), .flag_a_oe(fa_oe), .flag_b_oe(fb_oe), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_en(pull_en), .ext_drv(ext_drv), .ext_en(ext_en), .flag_a_level(fa_lvl), .flag_b_level(fb_lvl),
    .pin_level(pin_in));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic wr(input logic [7:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdreg(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdreg
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic report_and_stop();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // The whole sequence takes about 260 cycles, so the 4000-cycle limit leaves wide margin.
  initial begin
    #20000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    {resetn, reg_wr, reg_rd, bus_rst, susp, cfg, rx_busy, tx_busy, hdx, send_req, term_req} = '0;
    {reg_addr, reg_wdata, ext_drv, ext_en} = '0;
    mismatches = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    cyc(2);
    `CHK({fa_lvl, fb_lvl}, 2'b01)
    `CHK(pin_oe, 9'h04f)
    `CHK(pull_en, 9'h0b0)
    foreach (offs[i]) begin
      rdreg(offs[i]);
      `CHK(rd, defs[i])
    end
    $display("reset defaults done");
    foreach (rows[i]) begin
      wr(OFS_FLAG_A, 32'(rows[i].setup));
      wr(OFS_FLAG_B, 32'(rows[i].setup));
      wr(OFS_MAX_PWR, 32'(rows[i].pwr));
      @(posedge clk);
      susp <= rows[i].s;
      cfg  <= rows[i].c;
      cyc(3);
      `CHK(fa_lvl, rows[i].lvl)
      `CHK(fb_lvl, rows[i].lvl)
    end
    $display("flag conditions done");
    wr(OFS_PIN_FUNC, 32'h1ff);
    @(posedge clk);
    ext_en   <= 9'h0b4;
    hdx      <= 1'b1;
    send_req <= 1'b1;
    term_req <= 1'b1;
    cyc(8);
    `CHK({set_act, ring_act, car_act, clr_act, wake_req}, 5'b11110)
    `CHK({pin_out[3], pin_oe[3], pin_out[6], pin_oe[6], pin_out[8], pin_oe[8]}, 6'b011101)
    wr(OFS_PIN_FUNC, 32'h7ff);
    cyc(3);
    `CHK({ring_act, wake_req, pin_out[8], pin_oe[8]}, 4'b0111)
    $display("alternate functions done");
    @(posedge clk);
    ext_en <= '0;
    susp   <= 1'b0;
    wr(OFS_PIN_FUNC, 32'h0);
    wr(OFS_GPIO_DIR, 32'h1ff);
    wr(OFS_GPIO_OUT, 32'h155);
    cyc(2);
    `CHK({pin_oe, pin_out}, {9'h1ff, 9'h155})
    wr(OFS_GPIO_DIR, 32'h0);
    wr(OFS_PULL_EN, 32'h1ff);
    @(posedge clk);
    susp <= 1'b1;
    cyc(6);
    rdreg(OFS_STATUS);
    `CHK({rd[8:0], pull_en}, {9'h1ff, 9'h1ff})
    @(posedge clk);
    bus_rst <= 1'b1;
    wr(OFS_PULL_EN, 32'h0);
    rdreg(OFS_PIN_FUNC);
    `CHK({rd, pull_en}, {32'h1c3, 9'h000})
    @(posedge clk);
    bus_rst <= 1'b0;
    cyc(2);
    `CHK(pull_en, 9'h0b0)
    $display("bus reset done");
    @(posedge clk);
    rx_busy <= 1'b1;
    tx_busy <= 1'b1;
    n_rx = 0;
    n_tx = 0;
    pv = pin_out[1:0];
    repeat (80) begin
      cyc(1);
      n_rx += int'(pin_out[0] !== pv[0]);
      n_tx += int'(pin_out[1] !== pv[1]);
      pv = pin_out[1:0];
    end
    `CHK({n_rx inside {[9:10]}, n_tx inside {[9:10]}}, 2'b11)
    @(posedge clk);
    rx_busy <= 1'b0;
    tx_busy <= 1'b0;
    cyc(3);
    `CHK(pin_out[1:0], 2'b00)
    $display("activity indicators done");
    report_and_stop();
  end
endmodule : uspd_top_tb
`default_nettype wire
